// >>> shared/cmpdc_pkg.sv
// shared constants and carrier types of the comparator digital control
package cmpdc_pkg;
  ////////////////////////////////////////////////////////////////////////
  // register offsets on the plain register port
  localparam logic [2:0] CMPDC_OFS_MAIN = 3'h0; // comparator_main_control
  localparam logic [2:0] CMPDC_OFS_EDGE = 3'h1; // comparator_edge_control
  localparam logic [2:0] CMPDC_OFS_NCH = 3'h2; // negative_channel_select
  localparam logic [2:0] CMPDC_OFS_PCH = 3'h3; // positive_channel_select
  localparam logic [2:0] CMPDC_OFS_OUT = 3'h4; // shared_result_register
  localparam logic [2:0] CMPDC_OFS_IRQ = 3'h5; // flag and interrupt enable
  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CMPDC_BIT_ON = 7; // cmp_enable_bit
  localparam int CMPDC_BIT_OUT = 6; // cmp_result_bit
  localparam int CMPDC_BIT_POL = 4; // cmp_invert_bit
  localparam int CMPDC_BIT_HYS = 1; // cmp_hysteresis_bit
  localparam int CMPDC_BIT_SYNC = 0; // cmp_sync_mode_bit
  localparam int CMPDC_BIT_RISE = 1; // rising_edge_enable
  localparam int CMPDC_BIT_FALL = 0; // falling_edge_enable
  localparam int CMPDC_BIT_MIRROR = 0; // cmp_result_mirror
  localparam int CMPDC_BIT_FLAG = 0; // cmp_interrupt_flag
  localparam int CMPDC_BIT_IE = 1; // cmp_interrupt_enable
  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] CMPDC_RST_MAIN = 8'h00;
  localparam logic [1:0] CMPDC_RST_EDGE = 2'h0;
  localparam logic [2:0] CMPDC_RST_CH = 3'h0;
  localparam logic [7:0] CMPDC_RD_ZERO = 8'h00;
  ////////////////////////////////////////////////////////////////////////
  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wrData;
    logic wrStb;
    logic rdStb;
  } cmpdc_bus_t;
  // controls toward the analog comparator and its input muxes
  typedef struct packed {
    logic powerOn;
    logic hystOn;
    logic inputsOn;
    logic [2:0] posSel;
    logic [2:0] negSel;
  } cmpdc_analog_t;
endpackage : cmpdc_pkg

// >>> design/cmpdc_top.sv
// digital control around one analog voltage comparator
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
// Behaviour
// - enable bit powers comparator, clear saves power
// - result readable in control and mirror registers
// - internal result registered every instruction cycle
// - high when positive above negative, invertible
// - hysteresis bit drives analog hysteresis enable
// - adjusted output offered as timer gate
// - sync mode captures on timer clock fall
// - capture on falling edge avoids counting race
// - async mode passes output without capture
// - rising and falling edges gated set flag
// - flag sticky, set beats software clear
// - edge detection runs while comparator disabled
// - positive channel select, inputs off when disabled
// - negative channel select from three-bit field
// - active output with source enable shuts generator
// - works in sleep, sync stops on system clock
// - enabled interrupt raises wake from sleep
// - edge enables at bits one and zero
module cmpdc_top
  import cmpdc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire cmpdc_bus_t busReq,
  output logic [7:0] rdData,
  // analog comparator and timer side
  input wire logic cmpRaw,
  input wire logic tmrClkLvl,
  input wire logic tmrClkIsSys,
  input wire logic sleepMode,
  input wire logic shutdownSrcEn,
  output cmpdc_analog_t analogCtl,
  // digital results
  output logic timerGate,
  output logic pinOut,
  output logic shutdownReq,
  output logic irqFlag,
  output logic wakeReq
);
  ////////////////////////////////////////////////////////////////////////
  // control registers
  logic ctlOn_q, ctlOn_d; // comparator enable
  logic ctlPol_q, ctlPol_d; // output inversion
  logic ctlHys_q, ctlHys_d; // hysteresis enable
  logic ctlSync_q, ctlSync_d; // timer synchronised output
  logic [1:0] edgeEn_q, edgeEn_d; // rising and falling enables
  logic [2:0] negSel_q, negSel_d; // inverting input mux
  logic [2:0] posSel_q, posSel_d; // non-inverting input mux
  logic irqEn_q, irqEn_d; // interrupt enable
  logic [7:0] rdData_q, rdData_d; // read data, one cycle after strobe

  // true when a write hits the given offset
  function automatic logic wrHit(input cmpdc_bus_t r, input logic [2:0] ofs);
    wrHit = r.wrStb && (r.addr == ofs);
  endfunction : wrHit

  ////////////////////////////////////////////////////////////////////////
  // result path state
  logic result_q, result_d; // registered adjusted result
  logic resultPrev_q, resultPrev_d; // previous cycle copy for edges
  logic tmrPrev_q, tmrPrev_d; // last timer clock level
  logic syncOut_q, syncOut_d; // timer synchronised capture
  logic extOut_q, extOut_d; // output toward timer gate and pin
  logic shut_q, shut_d; // shutdown request register
  logic flag_q, flag_d; // sticky interrupt flag
  logic wake_q, wake_d; // wake request register
  logic cmpAdj; // polarity adjusted comparator level
  logic tmrFall; // falling edge of the timer clock
  logic syncFrozen; // timer halted in sleep
  logic edgeRise, edgeFall, edgeEvt; // detected transitions
  logic flagClr; // software clear of the flag

  ////////////////////////////////////////////////////////////////////////
  // next values of the control registers
  always_comb
  begin
    ctlOn_d = ctlOn_q;
    ctlPol_d = ctlPol_q;
    ctlHys_d = ctlHys_q;
    ctlSync_d = ctlSync_q;
    edgeEn_d = edgeEn_q;
    negSel_d = negSel_q;
    posSel_d = posSel_q;
    irqEn_d = irqEn_q;
    // result bit is read only; writes to it are dropped
    if (wrHit(busReq, CMPDC_OFS_MAIN))
    begin
      ctlOn_d = busReq.wrData[CMPDC_BIT_ON];
      ctlPol_d = busReq.wrData[CMPDC_BIT_POL];
      ctlHys_d = busReq.wrData[CMPDC_BIT_HYS];
      ctlSync_d = busReq.wrData[CMPDC_BIT_SYNC];
    end
    if (wrHit(busReq, CMPDC_OFS_EDGE))
    begin
      edgeEn_d[CMPDC_BIT_RISE] = busReq.wrData[CMPDC_BIT_RISE];
      edgeEn_d[CMPDC_BIT_FALL] = busReq.wrData[CMPDC_BIT_FALL];
    end
    if (wrHit(busReq, CMPDC_OFS_NCH))
    begin
      negSel_d = busReq.wrData[2:0];
    end
    if (wrHit(busReq, CMPDC_OFS_PCH))
    begin
      posSel_d = busReq.wrData[2:0];
    end
    if (wrHit(busReq, CMPDC_OFS_IRQ))
    begin
      irqEn_d = busReq.wrData[CMPDC_BIT_IE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data mux, zero for unmapped offsets and idle cycles
  always_comb
  begin
    rdData_d = CMPDC_RD_ZERO;
    if (busReq.rdStb)
    begin
      unique case (busReq.addr)
        CMPDC_OFS_MAIN:
        begin
          rdData_d[CMPDC_BIT_ON] = ctlOn_q;
          rdData_d[CMPDC_BIT_OUT] = result_q;
          rdData_d[CMPDC_BIT_POL] = ctlPol_q;
          rdData_d[CMPDC_BIT_HYS] = ctlHys_q;
          rdData_d[CMPDC_BIT_SYNC] = ctlSync_q;
        end
        CMPDC_OFS_EDGE: rdData_d[1:0] = edgeEn_q;
        CMPDC_OFS_NCH: rdData_d[2:0] = negSel_q;
        CMPDC_OFS_PCH: rdData_d[2:0] = posSel_q;
        CMPDC_OFS_OUT: rdData_d[CMPDC_BIT_MIRROR] = result_q;
        CMPDC_OFS_IRQ:
        begin
          rdData_d[CMPDC_BIT_FLAG] = flag_q;
          rdData_d[CMPDC_BIT_IE] = irqEn_q;
        end
        default: rdData_d = CMPDC_RD_ZERO; // unmapped offsets
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers and read data
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctlOn_q <= CMPDC_RST_MAIN[CMPDC_BIT_ON];
      ctlPol_q <= CMPDC_RST_MAIN[CMPDC_BIT_POL];
      ctlHys_q <= CMPDC_RST_MAIN[CMPDC_BIT_HYS];
      ctlSync_q <= CMPDC_RST_MAIN[CMPDC_BIT_SYNC];
      edgeEn_q <= CMPDC_RST_EDGE;
      negSel_q <= CMPDC_RST_CH;
      posSel_q <= CMPDC_RST_CH;
      irqEn_q <= 1'b0;
      rdData_q <= CMPDC_RD_ZERO;
    end
    else
    begin
      ctlOn_q <= ctlOn_d;
      ctlPol_q <= ctlPol_d;
      ctlHys_q <= ctlHys_d;
      ctlSync_q <= ctlSync_d;
      edgeEn_q <= edgeEn_d;
      negSel_q <= negSel_d;
      posSel_q <= posSel_d;
      irqEn_q <= irqEn_d;
      rdData_q <= rdData_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result path, edges, flag and side outputs
  always_comb
  begin
    // a disabled comparator reads as low before inversion, so toggling enable or
    // inversion still makes edges that software can see
    cmpAdj = (ctlOn_q & cmpRaw) ^ ctlPol_q;
    result_d = cmpAdj;
    resultPrev_d = result_q;
    edgeRise = result_q & ~resultPrev_q;
    edgeFall = ~result_q & resultPrev_q;
    edgeEvt = (edgeRise & edgeEn_q[CMPDC_BIT_RISE])
            | (edgeFall & edgeEn_q[CMPDC_BIT_FALL]);
    // write with the flag bit low clears it; a new edge still wins
    flagClr = wrHit(busReq, CMPDC_OFS_IRQ) & ~busReq.wrData[CMPDC_BIT_FLAG];
    flag_d = (flag_q & ~flagClr) | edgeEvt;
    wake_d = flag_d & irqEn_q;
    // timer clocked from the system clock halts in sleep
    syncFrozen = sleepMode & tmrClkIsSys;
    tmrPrev_d = tmrClkLvl;
    // falling edge keeps capture away from the rising count edge
    tmrFall = tmrPrev_q & ~tmrClkLvl;
    syncOut_d = syncOut_q;
    if (tmrFall && !syncFrozen)
    begin
      syncOut_d = cmpAdj;
    end
    // async mode costs one output flop, kept so outputs stay glitch free
    extOut_d = ctlSync_q ? syncOut_d : cmpAdj;
    shut_d = extOut_d & shutdownSrcEn;
  end

  // registers of the result path
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      result_q <= 1'b0;
      resultPrev_q <= 1'b0;
      tmrPrev_q <= 1'b0;
      syncOut_q <= 1'b0;
      extOut_q <= 1'b0;
      shut_q <= 1'b0;
      flag_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      result_q <= result_d;
      resultPrev_q <= resultPrev_d;
      tmrPrev_q <= tmrPrev_d;
      syncOut_q <= syncOut_d;
      extOut_q <= extOut_d;
      shut_q <= shut_d;
      flag_q <= flag_d;
      wake_q <= wake_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign rdData = rdData_q;
  // one driver for the whole analog control word
  assign analogCtl = '{
    powerOn: ctlOn_q,
    hystOn: ctlHys_q,
    inputsOn: ctlOn_q,
    posSel: posSel_q,
    negSel: negSel_q
  };
  assign timerGate = extOut_q;
  assign pinOut = extOut_q;
  assign shutdownReq = shut_q;
  assign irqFlag = flag_q;
  assign wakeReq = wake_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // an enabled rising edge one cycle after the raw change
  sequence s_riseSeen;
    edgeEn_q[CMPDC_BIT_RISE] && !result_q ##1 result_q;
  endsequence
  sequence s_clearReq;
    flagClr && !edgeEvt;
  endsequence

  a_flag_on_rise: assert property (s_riseSeen |=> flag_q)
    else $error("enabled rising edge did not set flag");
  a_flag_sticky: assert property (flag_q && !flagClr |=> flag_q)
    else $error("flag dropped without clear");
  a_set_beats_clear: assert property (flagClr && edgeEvt |=> flag_q)
    else $error("clear won over a new edge");
  a_clear_works: assert property (s_clearReq |=> !flag_q)
    else $error("flag not cleared");
  a_result_tracks: assert property
    (result_q == $past((ctlOn_q & cmpRaw) ^ ctlPol_q))
    else $error("registered result wrong");
  a_off_low_result: assert property
    (!ctlOn_q && !ctlPol_q && $stable(ctlOn_q) && $stable(ctlPol_q) |=> !result_q)
    else $error("disabled result not low");
  a_sync_hold: assert property
    (ctlSync_q && !tmrFall && $stable(ctlSync_q) |=> $stable(extOut_q))
    else $error("sync output moved off timer fall");
  a_async_path: assert property
    (!ctlSync_q |=> extOut_q == $past(cmpAdj))
    else $error("async output not following comparator");
  a_sleep_freeze: assert property
    (syncFrozen && ctlSync_q ##1 syncFrozen && ctlSync_q |-> $stable(syncOut_q))
    else $error("sync capture ran in sleep");
  a_shutdown_req: assert property
    (shutdownReq == $past(extOut_d & shutdownSrcEn))
    else $error("shutdown request wrong");
  // wake rises with the flag, gated by the enable of the cycle before
  a_wake_req: assert property (wakeReq == (irqFlag && $past(irqEn_q)))
    else $error("wake request not following flag and enable");
  a_read_latency: assert property
    (busReq.rdStb && busReq.addr == CMPDC_OFS_OUT |=> rdData == {7'h00, $past(result_q)})
    else $error("mirror read wrong");
  a_power_bit: assert property
    (wrHit(busReq, CMPDC_OFS_MAIN) |=> analogCtl.powerOn == $past(busReq.wrData[CMPDC_BIT_ON]))
    else $error("enable bit not applied");
endmodule : cmpdc_top

// >>> tb/cmpdc_far_model.sv
// far side model: analog comparator result and timer clock source
`timescale 1ns/100ps
module cmpdc_far_model
(
  // clock
  input wire logic sys_clk,
  // commands from the bench
  input wire logic wantRaw,
  input wire logic tmrRun,
  // toward the block
  output logic cmpRaw,
  output logic tmrClkLvl
);
  // divider keeps the timer clock well below the instruction clock
  logic [1:0] divCnt_q;
  ////////////////////////////////////////////////////////////////////////
  // known levels from time zero, timer clock idles high
  initial
  begin
    cmpRaw = 1'b0;
    tmrClkLvl = 1'b1;
    divCnt_q = 2'h0;
  end
  // result settles one edge after the command, timer clock stops when idle
  always @(posedge sys_clk)
  begin
    cmpRaw <= wantRaw;
    divCnt_q <= divCnt_q + 2'h1;
    if (tmrRun && divCnt_q == 2'h3)
    begin
      tmrClkLvl <= ~tmrClkLvl;
    end
  end
endmodule : cmpdc_far_model

// >>> tb/cmpdc_top_tb.sv
// self-checking bench of the comparator digital control
`timescale 1ns/100ps
module cmpdc_top_tb;
  import cmpdc_pkg::*;
  // clock, reset and stimulus
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  cmpdc_bus_t busReq = '0;
  logic wantRaw = 1'b0;
  logic tmrRun = 1'b0;
  logic tmrClkIsSys = 1'b0;
  logic sleepMode = 1'b0;
  logic shutdownSrcEn = 1'b0;
  // design outputs and model wires
  logic [7:0] rdData;
  logic cmpRaw, tmrClkLvl, timerGate, pinOut, shutdownReq, irqFlag, wakeReq;
  cmpdc_analog_t analogCtl;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////
  cmpdc_top dut (.sys_clk(sys_clk), .reset(reset), .busReq(busReq), .rdData(rdData),
    .cmpRaw(cmpRaw), .tmrClkLvl(tmrClkLvl), .tmrClkIsSys(tmrClkIsSys),
    .sleepMode(sleepMode), .shutdownSrcEn(shutdownSrcEn), .analogCtl(analogCtl),
    .timerGate(timerGate), .pinOut(pinOut), .shutdownReq(shutdownReq),
    .irqFlag(irqFlag), .wakeReq(wakeReq));
  cmpdc_far_model far (.sys_clk(sys_clk), .wantRaw(wantRaw), .tmrRun(tmrRun),
    .cmpRaw(cmpRaw), .tmrClkLvl(tmrClkLvl));
  // 10 MHz instruction clock
  always #50 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // one compare for every byte or bit result
  task automatic chk(string what, logic [7:0] expVal, logic [7:0] gotVal);
    comparisons++;
    if (gotVal !== expVal)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, expVal, gotVal);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
    @(posedge sys_clk);
    busReq <= '0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(string what, logic [2:0] a, logic [7:0] e);
    @(posedge sys_clk);
    busReq <= '{addr: a, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b1};
    @(posedge sys_clk);
    busReq <= '0;
    @(negedge sys_clk);
    chk(what, e, rdData);
  endtask : rd_chk
  // let the result path settle, a few cycles beyond its latency
  task automatic settle(int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////
  // reset values, unmapped offsets and read-only bits
  task automatic t_regs();
    rd_chk("main", CMPDC_OFS_MAIN, CMPDC_RST_MAIN);
    rd_chk("edge", CMPDC_OFS_EDGE, 8'h00);
    rd_chk("out", CMPDC_OFS_OUT, 8'h00);
    rd_chk("gap6", 3'h6, CMPDC_RD_ZERO);
    wr(3'h7, 8'hFF);
    wr(CMPDC_OFS_EDGE, 8'hFF);
    rd_chk("edgeMask", CMPDC_OFS_EDGE, 8'h03);
    wr(CMPDC_OFS_EDGE, 8'h00);
    wr(CMPDC_OFS_MAIN, 8'h40);
    rd_chk("outRo", CMPDC_OFS_MAIN, 8'h00);
  endtask : t_regs
  // enable, hysteresis and both channel selects toward the analog side
  task automatic t_analog();
    wr(CMPDC_OFS_MAIN, 8'h82);
    wr(CMPDC_OFS_PCH, 8'h05);
    wr(CMPDC_OFS_NCH, 8'h06);
    settle(1);
    chk("powerOn", 8'h01, analogCtl.powerOn);
    chk("hystOn", 8'h01, analogCtl.hystOn);
    chk("posSel", 8'h05, analogCtl.posSel);
    chk("negSel", 8'h06, analogCtl.negSel);
    rd_chk("mainRb", CMPDC_OFS_MAIN, 8'h82);
    rd_chk("pchRb", CMPDC_OFS_PCH, 8'h05);
    rd_chk("nchRb", CMPDC_OFS_NCH, 8'h06);
    wr(CMPDC_OFS_MAIN, 8'h00);
    settle(1);
    chk("inputsOff", 8'h00, analogCtl.inputsOn);
    chk("powerOff", 8'h00, analogCtl.powerOn);
  endtask : t_analog
  // polarity, mirrors, gate and shutdown source; enabled edges set the flag, writes clear it
  task automatic t_result();
    wr(CMPDC_OFS_EDGE, 8'h02);
    wr(CMPDC_OFS_IRQ, 8'h02);
    wr(CMPDC_OFS_MAIN, 8'h80);
    wantRaw <= 1'b1;
    shutdownSrcEn <= 1'b1;
    settle(5);
    chk("flagRise", 8'h01, irqFlag);
    chk("wake", 8'h01, wakeReq);
    chk("gate", 8'h01, timerGate);
    chk("pin", 8'h01, pinOut);
    chk("shutdown", 8'h01, shutdownReq);
    rd_chk("resHigh", CMPDC_OFS_MAIN, 8'hC0);
    rd_chk("mirror", CMPDC_OFS_OUT, 8'h01);
    rd_chk("irqReg", CMPDC_OFS_IRQ, 8'h03);
    wr(CMPDC_OFS_IRQ, 8'h02);
    settle(1);
    chk("flagClr", 8'h00, irqFlag);
    wr(CMPDC_OFS_MAIN, 8'h90);
    settle(4);
    chk("inverted", 8'h00, timerGate);
    chk("noFallIrq", 8'h00, irqFlag);
    // inputs only move right after a rising edge
    @(posedge sys_clk);
    shutdownSrcEn <= 1'b0;
    wr(CMPDC_OFS_MAIN, 8'h80);
    settle(4);
    chk("srcOff", 8'h00, shutdownReq);
    chk("flagHeld", 8'h01, irqFlag);
    // writing the flag bit high keeps it; enable off drops the wake
    wr(CMPDC_OFS_IRQ, 8'h01);
    settle(1);
    chk("wakeNoIe", 8'h00, wakeReq);
    rd_chk("flagNoIe", CMPDC_OFS_IRQ, 8'h01);
    wr(CMPDC_OFS_IRQ, 8'h02);
  endtask : t_result
  // disabled comparator still makes an edge when the polarity flips
  task automatic t_disabled();
    wr(CMPDC_OFS_MAIN, 8'h00);
    settle(4);
    wr(CMPDC_OFS_IRQ, 8'h02);
    wr(CMPDC_OFS_MAIN, 8'h10);
    settle(4);
    chk("polEdge", 8'h01, irqFlag);
    wr(CMPDC_OFS_IRQ, 8'h02);
    wr(CMPDC_OFS_MAIN, 8'h00);
    settle(4);
    // back to back writes: the clear lands in the cycle of the new edge
    wr(CMPDC_OFS_MAIN, 8'h10);
    wr(CMPDC_OFS_IRQ, 8'h02);
    settle(1);
    chk("setWins", 8'h01, irqFlag);
    wr(CMPDC_OFS_IRQ, 8'h02);
  endtask : t_disabled
  // synchronised output follows only timer clock falls, frozen in sleep
  task automatic t_sync();
    wantRaw <= 1'b0;
    wr(CMPDC_OFS_MAIN, 8'h81);
    settle(4);
    @(posedge sys_clk);
    wantRaw <= 1'b1;
    settle(8);
    chk("syncHold", 8'h00, timerGate);
    @(posedge sys_clk);
    tmrRun <= 1'b1;
    settle(20);
    chk("syncFall", 8'h01, timerGate);
    @(posedge sys_clk);
    sleepMode <= 1'b1;
    tmrClkIsSys <= 1'b1;
    wantRaw <= 1'b0;
    settle(20);
    chk("sleepFrozen", 8'h01, pinOut);
    @(posedge sys_clk);
    sleepMode <= 1'b0;
    settle(20);
    chk("awake", 8'h00, pinOut);
  endtask : t_sync
  ////////////////////////////////////////////////////////////////////////
  // hang guard well beyond the two hundred or so cycles the sequence needs
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  // main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_analog();
    t_result();
    t_disabled();
    t_sync();
    wrap_up();
  end
endmodule : cmpdc_top_tb
